// file: rtl/dlpx_consts.svh
`ifndef DLPX_CONSTS_SVH
`define DLPX_CONSTS_SVH
// Extension framing
`define DLPX_EXT_TYPE 7'h03
`define DLPX_LEN_SHORT 8'h01
`define DLPX_LEN_TWO_PORT 8'h03
`define DLPX_LEN_FOUR_PORT 8'h04
`define DLPX_RSV_LAST 2'h2
`define DLPX_BEAM_LAST_FOUR 2'h2
`define DLPX_BEAM_LAST_TWO 2'h0
// Field limits and defaults
`define DLPX_LAYER_TXD 4'hf
`define DLPX_LAYER_MAX 4'h3
`define DLPX_COUNT_MAX 4'h3
`define DLPX_SCHEME_MAX 4'h2
`define DLPX_SYM_MAX 4'hd
`define DLPX_BOOK_DEFAULT 8'h00
`define DLPX_SECT_TYPE_A 4'h1
`define DLPX_SECT_TYPE_B 4'h3
`define DLPX_TM_MIN 3'h2
`define DLPX_TM_MAX 3'h4
`define DLPX_TM_BOOK 3'h4
// Register offsets and reset values
`define DLPX_REG_CTRL 4'h0
`define DLPX_REG_LAST 4'h4
`define DLPX_REG_ERR 4'h8
`define DLPX_REG_COUNT 4'hc
`define DLPX_CTRL_RESET 32'h0000_0001
// Error cause bit positions
`define DLPX_ERR_GATE 0
`define DLPX_ERR_TYPE 1
`define DLPX_ERR_LEN 2
`define DLPX_ERR_FIELD 3
`define DLPX_ERR_TRUNC 4
`define DLPX_ERR_BITS 5
`endif

// file: rtl/dlpx_pkg.sv
package dlpx_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_LEN = 4'h1,
    S_BOOK = 4'h3,
    S_LAYER = 4'h2,
    S_SCHEME = 4'h6,
    S_MASK = 4'h7,
    S_SYM = 4'h5,
    S_RSV = 4'h4,
    S_BEAM_HI = 4'hc,
    S_BEAM_LO = 4'hd,
    S_SKIP = 4'hf
  } dlpx_state_type;
  typedef logic [14:0] dlpx_beam_type;
endpackage : dlpx_pkg

// file: rtl/dlpx_beam_slot.sv
`timescale 1ns/1ps
module dlpx_beam_slot
  import dlpx_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic load_hi,
  input wire logic load_lo,
  input wire logic [7:0] octet,
  output dlpx_beam_type beam_ff,
  output logic unweighted_ff
);
  dlpx_beam_type nxt_beam;

  always_comb begin
    nxt_beam = beam_ff;
    if (clear) begin
      nxt_beam = '0;
    end else if (load_hi) begin
      nxt_beam = {octet[6:0], beam_ff[7:0]};
    end else if (load_lo) begin
      nxt_beam = {beam_ff[14:8], octet};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      beam_ff <= '0;
      unweighted_ff <= 1'b1;
    end else begin
      beam_ff <= nxt_beam;
      unweighted_ff <= (nxt_beam == '0);
    end
  end
endmodule : dlpx_beam_slot

// file: rtl/dlpx_parser.sv
// How it works
// - Extension accepted only in section types 1 or 3 and modes TM2 to TM4.
// - First octet: follows flag in bit 7, type code 0x03 below it.
// - Two ports: first-layer form carries port 1 beam only, length 0x3.
// - Four ports: first-layer form carries ports 1 to 3 beams, length 0x4.
// - Port 0 beam comes from the section header beam field.
// - Later-layer form is one word: type, length 0x01, book, layer nibbles.
// - Later layers ignore the header beam; sender sets it to default.
// - Each spatial layer has its own section; beams only in layer zero and layer 1111b.
// - Eight-bit codebook index; default zero outside TM4.
// - Four-bit layer: 0 to 3 select layers, 1111b marks transmit diversity.
// - Scheme codes 0, 1, 2 valid; all others reserved.
// - Layer count field holds layers minus one, up to 0011b.
// - Twelve-bit element mask, msb is lowest frequency element.
// - Symbol codes 0 to 13 valid; 1110b and 1111b reserved.
// - Shift flag zero for one layer; else reflects cell shift group.
// - Beam selectors are 15 bits; zero means unweighted equal drive.
// - One beam per port serves both data and reference elements.
`timescale 1ns/1ps
`include "dlpx_consts.svh"
module dlpx_parser
  import dlpx_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic byte_valid,
  input wire logic byte_start,
  input wire logic [7:0] byte_data,
  input wire logic [3:0] section_type,
  input wire logic [2:0] tx_mode,
  input wire logic [14:0] header_beam_selector,
  output logic result_valid,
  output logic ext_error,
  output logic extension_follows_flag,
  output logic [7:0] precoder_book_index,
  output logic [3:0] tx_layer_number,
  output logic [3:0] layer_count_code,
  output logic [3:0] transmission_scheme,
  output logic [11:0] refsig_element_mask,
  output logic [3:0] refsig_symbol_index,
  output logic refsig_shift_flag,
  output logic [14:0] port0_beam_selector,
  output logic [14:0] port1_beam_selector,
  output logic [14:0] port2_beam_selector,
  output logic [14:0] port3_beam_selector,
  output logic [3:0] port_unweighted
);
  dlpx_state_type state_ff, nxt_state;
  logic [7:0] len_ff;
  logic [1:0] cnt_ff;
  logic [2:0] tm_ff;
  dlpx_beam_type hdr_ff;
  logic ef_ff;
  logic [7:0] book_ff;
  logic [3:0] layer_ff, count_ff, scheme_ff, sym_ff;
  logic [11:0] mask_ff;
  logic shift_ff;
  logic enable_ff;
  logic [`DLPX_ERR_BITS-1:0] err_ff, err_cause, err_clr;
  logic [15:0] ok_cnt_ff;
  logic done, gate_ok, first, take, hit;
  logic [3:0] cur_layer, cur_count;
  logic [1:0] beam_last;
  logic [7:0] out_book;
  dlpx_beam_type out_port0;
  logic [31:0] rd_mux;
  logic result_valid_ff, ext_error_ff;
  logic [31:0] reg_rdata_ff;
  dlpx_beam_type beam_w [1:3];
  logic [3:1] unw_w;
  logic unw0_ff;
  dlpx_beam_type port0_ff;
  logic [7:0] book_out_ff;
  logic [3:0] layer_out_ff, count_out_ff, scheme_out_ff, sym_out_ff;
  logic [11:0] mask_out_ff;
  logic shift_out_ff, ef_out_ff;

  assign take = byte_valid && !byte_start;
  assign hit = byte_valid && byte_start && enable_ff;
  // Section type and mode gate
  assign gate_ok = (section_type == `DLPX_SECT_TYPE_A || section_type == `DLPX_SECT_TYPE_B)
                   && tx_mode >= `DLPX_TM_MIN && tx_mode <= `DLPX_TM_MAX;
  assign cur_layer = (state_ff == S_LAYER) ? byte_data[7:4] : layer_ff;
  assign cur_count = (state_ff == S_LAYER) ? byte_data[3:0] : count_ff;
  // Layer zero and transmit diversity both use the long form
  assign first = (cur_layer == 4'h0) || (cur_layer == `DLPX_LAYER_TXD);
  assign beam_last = (len_ff == `DLPX_LEN_FOUR_PORT) ? `DLPX_BEAM_LAST_FOUR
                                                     : `DLPX_BEAM_LAST_TWO;

  always_comb begin
    nxt_state = state_ff;
    err_cause = '0;
    done = 1'b0;
    if (hit) begin
      // A new start aborts a half-parsed extension
      if (state_ff != S_IDLE && state_ff != S_SKIP) begin
        err_cause[`DLPX_ERR_TRUNC] = 1'b1;
      end
      if (!gate_ok) begin
        err_cause[`DLPX_ERR_GATE] = 1'b1;
        nxt_state = S_SKIP;
      end else if (byte_data[6:0] != `DLPX_EXT_TYPE) begin
        err_cause[`DLPX_ERR_TYPE] = 1'b1;
        nxt_state = S_SKIP;
      end else begin
        nxt_state = S_LEN;
      end
    end else if (byte_valid && byte_start) begin
      nxt_state = S_IDLE;
    end else if (take) begin
      case (state_ff)
        S_LEN: begin
          if (byte_data == `DLPX_LEN_SHORT || byte_data == `DLPX_LEN_TWO_PORT
              || byte_data == `DLPX_LEN_FOUR_PORT) begin
            nxt_state = S_BOOK;
          end else begin
            err_cause[`DLPX_ERR_LEN] = 1'b1;
            nxt_state = S_SKIP;
          end
        end
        S_BOOK: nxt_state = S_LAYER;
        S_LAYER: begin
          if ((cur_layer > `DLPX_LAYER_MAX && cur_layer != `DLPX_LAYER_TXD)
              || cur_count > `DLPX_COUNT_MAX) begin
            err_cause[`DLPX_ERR_FIELD] = 1'b1;
            nxt_state = S_SKIP;
          end else if (first == (len_ff == `DLPX_LEN_SHORT)) begin
            err_cause[`DLPX_ERR_LEN] = 1'b1;
            nxt_state = S_SKIP;
          end else if (!first) begin
            done = 1'b1;
            nxt_state = S_IDLE;
          end else begin
            nxt_state = S_SCHEME;
          end
        end
        S_SCHEME: begin
          if (byte_data[7:4] > `DLPX_SCHEME_MAX) begin
            err_cause[`DLPX_ERR_FIELD] = 1'b1;
            nxt_state = S_SKIP;
          end else begin
            nxt_state = S_MASK;
          end
        end
        S_MASK: nxt_state = S_SYM;
        S_SYM: begin
          if (byte_data[3:0] > `DLPX_SYM_MAX || (byte_data[7] && count_ff == 4'h0)) begin
            err_cause[`DLPX_ERR_FIELD] = 1'b1;
            nxt_state = S_SKIP;
          end else begin
            nxt_state = S_RSV;
          end
        end
        S_RSV: begin
          if (cnt_ff == `DLPX_RSV_LAST) begin
            nxt_state = S_BEAM_HI;
          end
        end
        S_BEAM_HI: nxt_state = S_BEAM_LO;
        S_BEAM_LO: begin
          if (cnt_ff == beam_last) begin
            done = 1'b1;
            nxt_state = S_IDLE;
          end else begin
            nxt_state = S_BEAM_HI;
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Octet counter shared by the reserved run and the beam index
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_ff <= 2'h0;
    end else if (hit || (take && state_ff == S_SYM)) begin
      cnt_ff <= 2'h0;
    end else if (take && state_ff == S_RSV) begin
      cnt_ff <= (cnt_ff == `DLPX_RSV_LAST) ? 2'h0 : cnt_ff + 2'h1;
    end else if (take && state_ff == S_BEAM_LO) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  // Working fields; cleared at start so a short form leaves defaults
  always_ff @(posedge mclk) begin
    if (!reset_n || hit) begin
      len_ff <= 8'h00;
      ef_ff <= 1'b0;
      book_ff <= `DLPX_BOOK_DEFAULT;
      layer_ff <= `DLPX_LAYER_TXD;
      count_ff <= 4'h0;
      scheme_ff <= 4'h0;
      mask_ff <= 12'h000;
      sym_ff <= 4'h0;
      shift_ff <= 1'b0;
      tm_ff <= 3'h0;
      hdr_ff <= '0;
      if (reset_n) begin
        ef_ff <= byte_data[7];
        tm_ff <= tx_mode;
        hdr_ff <= header_beam_selector;
      end
    end else if (take) begin
      case (state_ff)
        S_LEN: len_ff <= byte_data;
        S_BOOK: book_ff <= byte_data;
        S_LAYER: begin
          layer_ff <= byte_data[7:4];
          count_ff <= byte_data[3:0];
        end
        S_SCHEME: begin
          scheme_ff <= byte_data[7:4];
          mask_ff[11:8] <= byte_data[3:0];
        end
        S_MASK: mask_ff[7:0] <= byte_data;
        S_SYM: begin
          shift_ff <= byte_data[7];
          sym_ff <= byte_data[3:0];
        end
        default: len_ff <= len_ff;
      endcase
    end
  end

  // Ports 1 to 3 come from the extension
  for (genvar g = 1; g <= 3; g++) begin : g_port
    dlpx_beam_slot u_slot (
      .mclk(mclk),
      .reset_n(reset_n),
      .clear(hit),
      .load_hi(take && state_ff == S_BEAM_HI && cnt_ff == 2'(g - 1)),
      .load_lo(take && state_ff == S_BEAM_LO && cnt_ff == 2'(g - 1)),
      .octet(byte_data),
      .beam_ff(beam_w[g]),
      .unweighted_ff(unw_w[g])
    );
  end

  // Codebook is meaningless below TM4, so report the default there
  assign out_book = (tm_ff == `DLPX_TM_BOOK) ? book_ff : `DLPX_BOOK_DEFAULT;
  // Header beam only applies to the first layer
  assign out_port0 = first ? hdr_ff : '0;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      port0_ff <= '0;
      unw0_ff <= 1'b1;
      book_out_ff <= `DLPX_BOOK_DEFAULT;
      layer_out_ff <= `DLPX_LAYER_TXD;
      count_out_ff <= 4'h0;
      scheme_out_ff <= 4'h0;
      mask_out_ff <= 12'h000;
      sym_out_ff <= 4'h0;
      shift_out_ff <= 1'b0;
      ef_out_ff <= 1'b0;
    end else if (done) begin
      port0_ff <= out_port0;
      unw0_ff <= (out_port0 == '0);
      book_out_ff <= out_book;
      layer_out_ff <= cur_layer;
      count_out_ff <= cur_count;
      scheme_out_ff <= scheme_ff;
      mask_out_ff <= mask_ff;
      sym_out_ff <= sym_ff;
      shift_out_ff <= shift_ff;
      ef_out_ff <= ef_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      result_valid_ff <= 1'b0;
      ext_error_ff <= 1'b0;
    end else begin
      result_valid_ff <= done;
      ext_error_ff <= |err_cause;
    end
  end

  // Register file
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      enable_ff <= 1'(`DLPX_CTRL_RESET);
    end else if (reg_wr && reg_addr == `DLPX_REG_CTRL) begin
      enable_ff <= reg_wdata[0];
    end
  end

  assign err_clr = (reg_wr && reg_addr == `DLPX_REG_ERR) ? reg_wdata[`DLPX_ERR_BITS-1:0] : '0;

  // A cause raised in the clearing cycle stays set
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      err_ff <= '0;
    end else begin
      err_ff <= (err_ff & ~err_clr) | err_cause;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ok_cnt_ff <= 16'h0000;
    end else if (reg_wr && reg_addr == `DLPX_REG_COUNT) begin
      ok_cnt_ff <= {15'h0000, done};
    end else begin
      ok_cnt_ff <= ok_cnt_ff + {15'h0000, done};
    end
  end

  always_comb begin
    case (reg_addr)
      `DLPX_REG_CTRL: rd_mux = {31'h0000_0000, enable_ff};
      `DLPX_REG_LAST: rd_mux = {6'h00, ef_out_ff, sym_out_ff, shift_out_ff, scheme_out_ff,
                                count_out_ff, layer_out_ff, book_out_ff};
      `DLPX_REG_ERR: rd_mux = {27'h000_0000, err_ff};
      `DLPX_REG_COUNT: rd_mux = {16'h0000, ok_cnt_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign result_valid = result_valid_ff;
  assign ext_error = ext_error_ff;
  assign extension_follows_flag = ef_out_ff;
  assign precoder_book_index = book_out_ff;
  assign tx_layer_number = layer_out_ff;
  assign layer_count_code = count_out_ff;
  assign transmission_scheme = scheme_out_ff;
  assign refsig_element_mask = mask_out_ff;
  assign refsig_symbol_index = sym_out_ff;
  assign refsig_shift_flag = shift_out_ff;
  // Same selector drives data and reference elements of a port
  assign port0_beam_selector = port0_ff;
  assign port1_beam_selector = beam_w[1];
  assign port2_beam_selector = beam_w[2];
  assign port3_beam_selector = beam_w[3];
  assign port_unweighted = {unw_w[3], unw_w[2], unw_w[1], unw0_ff};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_bad_start;
    hit && (byte_data[6:0] != `DLPX_EXT_TYPE) && gate_ok;
  endsequence
  sequence s_short_layer;
    take && state_ff == S_LAYER && len_ff == `DLPX_LEN_SHORT
      && byte_data[7:4] >= 4'h1 && byte_data[7:4] <= `DLPX_LAYER_MAX
      && byte_data[3:0] <= `DLPX_COUNT_MAX;
  endsequence

  a_type_check: assert property (s_bad_start |=> ext_error && state_ff == S_SKIP)
    else $error("bad type code not flagged");
  a_gate_check: assert property (hit && !gate_ok |=> ext_error ##1 !result_valid)
    else $error("ungated extension accepted");
  a_short_done: assert property (s_short_layer |=> result_valid ##1 !result_valid)
    else $error("short form not completed in one word");
  a_short_beams: assert property (result_valid && tx_layer_number inside {[4'h1:4'h3]}
    |-> port0_beam_selector == '0 && port1_beam_selector == '0)
    else $error("later layer carries a beam");
  a_port0_header: assert property (result_valid && tx_layer_number == 4'h0
    |-> port0_beam_selector == $past(hdr_ff))
    else $error("port 0 beam not from header");
  a_book_default: assert property (result_valid && $past(tm_ff) != `DLPX_TM_BOOK
    |-> precoder_book_index == `DLPX_BOOK_DEFAULT)
    else $error("codebook not defaulted");
  a_two_port: assert property (result_valid && $past(len_ff) == `DLPX_LEN_TWO_PORT
    |-> port2_beam_selector == '0 && port3_beam_selector == '0)
    else $error("two-port form filled extra beams");
  a_sym_reserved: assert property (take && state_ff == S_SYM && byte_data[3:0] > `DLPX_SYM_MAX
    |=> ext_error ##1 !result_valid)
    else $error("reserved symbol accepted");
  a_shift_single: assert property (result_valid && layer_count_code == 4'h0
    |-> !refsig_shift_flag)
    else $error("shift set for one layer");
  a_four_port: assert property (take && state_ff == S_BEAM_LO && cnt_ff == 2'h2
    |=> result_valid && $past(len_ff) == `DLPX_LEN_FOUR_PORT)
    else $error("four-port form ended wrongly");
endmodule : dlpx_parser

// file: tb/dlpx_sender.sv
`timescale 1ns/1ps
module dlpx_sender (
  output logic byte_valid,
  output logic byte_start,
  output logic [7:0] byte_data,
  output logic [3:0] section_type,
  output logic [2:0] tx_mode,
  output logic [14:0] header_beam_selector,
  input wire logic mclk
);
  logic [7:0] fr [16];
  initial begin
    byte_valid = 1'b0;
    byte_start = 1'b0;
    byte_data = 8'h00;
    section_type = 4'h1;
    tx_mode = 3'h2;
    header_beam_selector = 15'h0000;
  end
  // Layers 0 and 1111b take the long form, others the one-word form
  task automatic build(input logic ef, input logic four, input logic [7:0] bk,
    input logic [3:0] ly, input logic [3:0] cnt, input logic [3:0] sch,
    input logic [11:0] msk, input logic [3:0] sym, input logic sh,
    input logic [14:0] b1, input logic [14:0] b2, input logic [14:0] b3);
    logic lng;
    lng = (ly == 4'h0) || (ly == 4'hf);
    fr[0] = {ef, 7'h03};
    fr[1] = !lng ? 8'h01 : (four ? 8'h04 : 8'h03);
    fr[2] = bk;
    fr[3] = {ly, cnt};
    fr[4] = {sch, msk[11:8]};
    fr[5] = msk[7:0];
    fr[6] = {sh, 3'h0, sym};
    for (int i = 7; i < 10; i++) begin
      fr[i] = 8'h00;
    end
    fr[10] = {1'b0, b1[14:8]};
    fr[11] = b1[7:0];
    fr[12] = {1'b0, b2[14:8]};
    fr[13] = b2[7:0];
    fr[14] = {1'b0, b3[14:8]};
    fr[15] = b3[7:0];
  endtask : build
  // Idle data shows the inverse of the last octet, never a held value
  task automatic send(input int n, input logic [3:0] st, input logic [2:0] md,
    input logic [14:0] hb, input int g);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      byte_valid <= 1'b1;
      byte_start <= (i == 0);
      byte_data <= fr[i];
      if (i == 0) begin
        section_type <= st;
        tx_mode <= md;
        header_beam_selector <= hb;
      end
      repeat (g) begin
        @(posedge mclk);
        byte_valid <= 1'b0;
        byte_start <= 1'b0;
        byte_data <= ~fr[i];
      end
    end
    @(posedge mclk);
    byte_valid <= 1'b0;
    byte_start <= 1'b0;
    byte_data <= ~fr[n-1];
  endtask : send
endmodule : dlpx_sender

// file: tb/dl_precoding_ext_parser_test.sv
`timescale 1ns/1ps
module dl_precoding_ext_parser_test;
  import dlpx_pkg::*;
  logic mclk, reset_n, reg_wr, reg_rd, byte_valid, byte_start, result_valid, ext_error;
  logic [3:0] reg_addr, section_type, tx_layer_number, layer_count_code;
  logic [3:0] transmission_scheme, refsig_symbol_index, port_unweighted;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] byte_data, precoder_book_index;
  logic [2:0] tx_mode;
  logic [14:0] header_beam_selector, port0_beam_selector, port1_beam_selector;
  logic [14:0] port2_beam_selector, port3_beam_selector;
  logic [11:0] refsig_element_mask;
  logic extension_follows_flag, refsig_shift_flag;
  logic ef, four, sh;
  logic [2:0] md;
  logic [3:0] st, ly, cnt, sch, sym;
  logic [7:0] bk;
  logic [11:0] msk;
  logic [14:0] b1, b2, b3, hb;
  logic [31:0] seed = 32'h0000_0021;
  int fails = 0, cmp_count = 0, oks = 0, errs = 0, cyc = 0, good_n = 0;
  int ebit [10] = '{0, 0, 1, 2, 3, 3, 2, 3, 3, 3};
  dlpx_parser dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .byte_valid(byte_valid), .byte_start(byte_start), .byte_data(byte_data),
    .section_type(section_type), .tx_mode(tx_mode),
    .header_beam_selector(header_beam_selector), .result_valid(result_valid),
    .ext_error(ext_error), .extension_follows_flag(extension_follows_flag),
    .precoder_book_index(precoder_book_index), .tx_layer_number(tx_layer_number),
    .layer_count_code(layer_count_code), .transmission_scheme(transmission_scheme),
    .refsig_element_mask(refsig_element_mask), .refsig_symbol_index(refsig_symbol_index),
    .refsig_shift_flag(refsig_shift_flag), .port0_beam_selector(port0_beam_selector),
    .port1_beam_selector(port1_beam_selector), .port2_beam_selector(port2_beam_selector),
    .port3_beam_selector(port3_beam_selector), .port_unweighted(port_unweighted));
  dlpx_sender snd (.byte_valid(byte_valid), .byte_start(byte_start),
    .byte_data(byte_data), .section_type(section_type), .tx_mode(tx_mode),
    .header_beam_selector(header_beam_selector), .mclk(mclk));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Pulses are counted at the edge so gaps in the octet stream do not matter
  always @(posedge mclk) begin
    cyc++;
    if (result_valid === 1'b1) oks++;
    if (ext_error === 1'b1) errs++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : chk_reg
  task automatic rand_fields(input logic lng);
    logic [31:0] r;
    r = rnd();
    ef = r[0];
    four = r[1];
    md = 3'h2 + 3'(r[3:2] % 3);
    st = r[4] ? 4'h1 : 4'h3;
    ly = lng ? (r[5] ? 4'hf : 4'h0) : 4'h1 + 4'(r[7:6] % 3);
    cnt = {2'h0, r[9:8]};
    sch = 4'(r[11:10] % 3);
    msk = r[23:12];
    sym = 4'(r[27:24] % 14);
    sh = (cnt != 4'h0) & r[28];
    r = rnd();
    bk = r[7:0];
    b1 = r[22:8];
    r = rnd();
    b2 = r[14:0];
    b3 = r[29:15];
    hb = r[31:17];
  endtask : rand_fields
  task automatic mk();
    snd.build(ef, four, bk, ly, cnt, sch, msk, sym, sh, b1, b2, b3);
  endtask : mk
  task automatic xmit(input int n, input int g, input int nok, input int ner);
    int o;
    int e;
    o = oks;
    e = errs;
    snd.send(n, st, md, hb, g);
    if (g == 0 && nok > 0) begin
      #1 chk(result_valid, 1'b1);
    end
    repeat (2) @(posedge mclk);
    chk(oks - o, nok);
    chk(errs - e, ner);
  endtask : xmit
  task automatic check_fields();
    logic l;
    logic [14:0] p0, p1, p2, p3;
    l = (ly == 4'h0) || (ly == 4'hf);
    p0 = l ? hb : 15'h0000;
    p1 = l ? b1 : 15'h0000;
    p2 = (l && four) ? b2 : 15'h0000;
    p3 = (l && four) ? b3 : 15'h0000;
    chk(extension_follows_flag, ef);
    chk(precoder_book_index, md == 3'h4 ? bk : 8'h00);
    chk({tx_layer_number, layer_count_code}, {ly, cnt});
    chk(transmission_scheme, l ? sch : 4'h0);
    chk(refsig_element_mask, l ? msk : 12'h000);
    chk({refsig_shift_flag, refsig_symbol_index}, {l & sh, l ? sym : 4'h0});
    chk({port0_beam_selector, port1_beam_selector}, {p0, p1});
    chk({port2_beam_selector, port3_beam_selector}, {p2, p3});
    chk(port_unweighted, {p3 == 0, p2 == 0, p1 == 0, p0 == 0});
    chk_reg(4'h4, {6'h00, ef, l ? sym : 4'h0, l & sh, l ? sch : 4'h0, cnt, ly,
      md == 3'h4 ? bk : 8'h00});
  endtask : check_fields
  task automatic frame_ok(input int g);
    mk();
    xmit((ly == 4'h0 || ly == 4'hf) ? (four ? 16 : 12) : 4, g, 1, 0);
    check_fields();
    good_n++;
  endtask : frame_ok
  initial begin
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    #1 chk({tx_layer_number, port_unweighted}, 8'hff);
    chk_reg(4'h0, 32'h0000_0001);
    chk_reg(4'h8, 32'h0000_0000);
    chk_reg(4'hc, 32'h0000_0000);
    chk_reg(4'h2, 32'h0000_0000);
    // Boundary values first: zero and all-ones beams, last symbol code, full mask
    rand_fields(1'b1);
    {four, ly, md, b1, b2, b3, sym, msk} = {1'b1, 4'h0, 3'h4, 15'h0, 15'h7fff, 15'h0, 4'hd, 12'hfff};
    frame_ok(0);
    for (int i = 0; i < 10; i++) begin
      rand_fields(1'b1);
      frame_ok(rnd() % 3);
    end
    for (int i = 0; i < 6; i++) begin
      rand_fields(1'b0);
      frame_ok(i % 2);
    end
    chk_reg(4'hc, good_n);
    // Each case breaks one thing; the cause bit must be the matching one
    for (int k = 0; k < 10; k++) begin
      rand_fields(k == 6 ? 1'b0 : 1'b1);
      four = 1'b1;
      if (k == 0) st = 4'h2;
      if (k == 1) md = 3'h1;
      mk();
      case (k)
        2: snd.fr[0] = {ef, 7'h04};
        3: snd.fr[1] = 8'h02;
        4: snd.fr[4][7:4] = 4'h3;
        5: snd.fr[6][3:0] = 4'he;
        6: snd.fr[1] = 8'h04;
        7: snd.fr[3][7:4] = 4'h5;
        8: snd.fr[3][3:0] = 4'h4;
        9: begin
          // One layer with the shift flag raised
          snd.fr[3][3:0] = 4'h0;
          snd.fr[6][7] = 1'b1;
        end
        default: ;
      endcase
      xmit(16, 0, 0, 1);
      chk_reg(4'h8, 32'h1 << ebit[k]);
      reg_write(4'h8, 32'hffff_ffff);
      chk_reg(4'h8, 32'h0000_0000);
    end
    rand_fields(1'b1);
    four = 1'b0;
    mk();
    xmit(6, 0, 0, 0);
    rand_fields(1'b0);
    mk();
    xmit(4, 0, 1, 1);
    chk_reg(4'h8, 32'h0000_0010);
    reg_write(4'h4, 32'hffff_ffff);
    check_fields();
    reg_write(4'h0, 32'h0000_0000);
    chk_reg(4'h0, 32'h0000_0000);
    rand_fields(1'b1);
    mk();
    xmit(16, 0, 0, 0);
    reg_write(4'h0, 32'h0000_0001);
    reg_write(4'hc, 32'h0000_1234);
    chk_reg(4'hc, 32'h0000_0000);
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    #1 chk({tx_layer_number, port_unweighted}, 8'hff);
    tally_and_finish();
  end
endmodule : dl_precoding_ext_parser_test
